// file: addr_decode_pkg.sv
// package: constants and types for the address space decoder
package addr_decode_pkg;

  // wishbone register offsets (byte addresses)
  localparam logic [7:0] BUS_CONTROL_ONE_OFFSET = 8'h00;
  localparam logic [7:0] DECODE_STATUS_OFFSET = 8'h04;
  localparam logic [7:0] MODE_STATUS_OFFSET = 8'h08;

  // bus_control_one reset value and field positions
  localparam logic [15:0] BUS_CONTROL_ONE_RESET = 16'h200F;
  localparam logic [15:0] BUS_CONTROL_ONE_WMASK = 16'h21FF;
  localparam int TIMER_ACCESS_BIT = 13;
  localparam int MUX_IO_BIT = 8;
  localparam int LONG_SIZE_LSB = 4;
  localparam int SIZE_LSB = 0;
  localparam int ADDR_BIT_FOURTEEN = 14;

  // address map boundaries
  localparam logic [7:0] EXT_TOP_BYTE = 8'h00;
  localparam logic [7:0] DRAM_TOP_BYTE = 8'h01;
  localparam logic [31:0] ROM_256K_END = 32'h0003FFFF;
  localparam logic [31:0] ROM_128K_END = 32'h0001FFFF;
  localparam logic [31:0] ROM_64K_END = 32'h0000FFFF;
  localparam logic [31:0] CS0_ROM_MODE_BASE = 32'h00200000;
  localparam logic [31:0] PERIPH_BASE = 32'hFFFF8000;
  localparam logic [31:0] PERIPH_END = 32'hFFFF87FF;
  localparam logic [31:0] RAM_BASE = 32'hFFFFF000;

  // rom size variants
  localparam logic [1:0] ROM_SIZE_256K = 2'h0;
  localparam logic [1:0] ROM_SIZE_128K = 2'h1;
  localparam logic [1:0] ROM_SIZE_64K = 2'h2;

  // decoded space kinds
  typedef enum logic [3:0] {
    SPACE_RESERVED = 4'h0,
    SPACE_ROM = 4'h1,
    SPACE_CS0 = 4'h2,
    SPACE_CS1 = 4'h3,
    SPACE_CS2 = 4'h4,
    SPACE_CS3 = 4'h5,
    SPACE_DRAM = 4'h6,
    SPACE_PERIPH = 4'h7,
    SPACE_RAM = 4'h8
  } space_e;

  // effective bus widths
  typedef enum logic [1:0] {
    WIDTH_8 = 2'h0,
    WIDTH_16 = 2'h1,
    WIDTH_32 = 2'h2
  } width_e;

  // wishbone slave states
  typedef enum logic [0:0] {
    WB_IDLE = 1'b0,
    WB_ACK = 1'b1
  } wb_state_e;

endpackage

// file: space_classifier.sv
// space classifier: maps a 32-bit address to its space kind
`timescale 1ns/1ps
module space_classifier (
  input wire logic [31:0] addr_in,
  input wire logic rom_enable_in,
  input wire logic [1:0] rom_size_in,
  input wire logic single_chip_in,
  output addr_decode_pkg::space_e space_out
);

  logic [31:0] rom_end;

  // rom end address per rom variant
  always_comb
  begin
    case (rom_size_in)
      addr_decode_pkg::ROM_SIZE_128K: rom_end = addr_decode_pkg::ROM_128K_END;
      addr_decode_pkg::ROM_SIZE_64K: rom_end = addr_decode_pkg::ROM_64K_END;
      default: rom_end = addr_decode_pkg::ROM_256K_END;
    endcase
  end

  // top byte picks the space kind, a23..a22 the area
  always_comb
  begin
    space_out = addr_decode_pkg::SPACE_RESERVED;
    if (addr_in[31:24] == addr_decode_pkg::EXT_TOP_BYTE)
    begin
      if (rom_enable_in && addr_in <= rom_end)
        space_out = addr_decode_pkg::SPACE_ROM;
      else if (rom_enable_in && addr_in < addr_decode_pkg::CS0_ROM_MODE_BASE)
        space_out = addr_decode_pkg::SPACE_RESERVED;
      else if (!single_chip_in)
      begin
        case (addr_in[23:22])
          2'h0: space_out = addr_decode_pkg::SPACE_CS0;
          2'h1: space_out = addr_decode_pkg::SPACE_CS1;
          2'h2: space_out = addr_decode_pkg::SPACE_CS2;
          default: space_out = addr_decode_pkg::SPACE_CS3;
        endcase
      end
    end
    else if (addr_in[31:24] == addr_decode_pkg::DRAM_TOP_BYTE)
    begin
      if (!single_chip_in)
        space_out = addr_decode_pkg::SPACE_DRAM;
    end
    else if (addr_in >= addr_decode_pkg::PERIPH_BASE && addr_in <= addr_decode_pkg::PERIPH_END)
      space_out = addr_decode_pkg::SPACE_PERIPH;
    else if (addr_in >= addr_decode_pkg::RAM_BASE)
      space_out = addr_decode_pkg::SPACE_RAM;
  end

endmodule

// file: width_selector.sv
// width selector: effective bus width of a decoded access
`timescale 1ns/1ps
module width_selector (
  input addr_decode_pkg::space_e space_in,
  input wire logic [15:0] control_in,
  input wire logic addr_fourteen_in,
  input wire logic rom_enable_in,
  input wire logic area_zero_mode_pin_in,
  input wire logic wide_package_in,
  output addr_decode_pkg::width_e width_out
);

  // width of an area from its long-size and size bits
  function automatic addr_decode_pkg::width_e area_width(input logic long_size, input logic size);
    if (long_size)
      area_width = addr_decode_pkg::WIDTH_32;
    else if (size)
      area_width = addr_decode_pkg::WIDTH_16;
    else
      area_width = addr_decode_pkg::WIDTH_8;
  endfunction

  // choose width per space
  always_comb
  begin
    case (space_in)
      addr_decode_pkg::SPACE_CS0:
        if (rom_enable_in)
          width_out = area_width(control_in[addr_decode_pkg::LONG_SIZE_LSB], control_in[addr_decode_pkg::SIZE_LSB]);
        else if (wide_package_in)
          width_out = area_zero_mode_pin_in ? addr_decode_pkg::WIDTH_32 : addr_decode_pkg::WIDTH_16;
        else
          width_out = area_zero_mode_pin_in ? addr_decode_pkg::WIDTH_16 : addr_decode_pkg::WIDTH_8;
      addr_decode_pkg::SPACE_CS1:
        width_out = area_width(control_in[addr_decode_pkg::LONG_SIZE_LSB + 1],
          control_in[addr_decode_pkg::SIZE_LSB + 1]);
      addr_decode_pkg::SPACE_CS2:
        width_out = area_width(control_in[addr_decode_pkg::LONG_SIZE_LSB + 2],
          control_in[addr_decode_pkg::SIZE_LSB + 2]);
      addr_decode_pkg::SPACE_CS3:
        if (control_in[addr_decode_pkg::MUX_IO_BIT])
          width_out = addr_fourteen_in ? addr_decode_pkg::WIDTH_16 : addr_decode_pkg::WIDTH_8;
        else
          width_out = area_width(control_in[addr_decode_pkg::LONG_SIZE_LSB + 3],
            control_in[addr_decode_pkg::SIZE_LSB + 3]);
      addr_decode_pkg::SPACE_DRAM:
        width_out = area_width(control_in[addr_decode_pkg::LONG_SIZE_LSB + 1],
          control_in[addr_decode_pkg::SIZE_LSB + 1]);
      addr_decode_pkg::SPACE_PERIPH: width_out = addr_decode_pkg::WIDTH_16;
      default: width_out = addr_decode_pkg::WIDTH_32;
    endcase
  end

endmodule

// file: address_space_decoder.sv
// address space decoder: space decode, chip selects, bus control register
// Functional notes
// - top address byte selects space, never output
// - zero top byte: a23..a22 drive chip selects
// - address bits 21..0 drive external pins
// - rom enabled: 256k rom, area zero 2 Mbytes
// - rom disabled: area zero from zero, 4 Mbytes
// - area three occupies the fourth 4-Mbyte window
// - areas one, two, dram width from register
// - single-chip mode disables all external spaces
// - rom disabled: area zero width from pins
// - smaller rom variants shrink the rom region
// - register resets to 200F on power-on
// - reserved bits read zero, write zero
// - bit 13 gates timer register access
// - bit 8 selects multiplexed area three
// - multiplexed width from address bit fourteen
// - bit 7 forces 32-bit area three
// - bit 6 forces 32-bit area two
// - size bit: 0 byte, 1 word, long overrides
// - area zero bits only with rom enabled
//
// Our own choices: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
module address_space_decoder (
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  // classic wishbone slave
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  // mode straps, sampled through two flip-flops
  input wire logic rom_enable_in,
  input wire logic [1:0] rom_size_in,
  input wire logic single_chip_in,
  input wire logic area_zero_mode_pin_in,
  input wire logic wide_package_in,
  // cpu side access
  input wire logic access_valid_in,
  input wire logic [31:0] access_addr_in,
  // external side
  output logic [21:0] ext_addr_out,
  output logic chip_select_zero_b_out,
  output logic chip_select_one_b_out,
  output logic chip_select_two_b_out,
  output logic chip_select_three_b_out,
  output logic dram_select_out,
  output logic mux_area_access_out,
  output logic [1:0] access_width_out,
  output logic [3:0] access_space_out,
  output logic timer_regs_access_enable_out,
  output logic mux_io_enable_out
);

  logic rst_sync1_r;
  logic rst_sync2_r;
  logic rst_b;
  logic [5:0] strap_sync1_r;
  logic [5:0] strap_sync2_r;
  logic [15:0] bus_control_one_r;
  logic [15:0] bus_control_one_nxt;
  addr_decode_pkg::wb_state_e wb_state_r;
  logic [31:0] rd_data;
  logic wb_req;
  addr_decode_pkg::space_e space;
  addr_decode_pkg::width_e width;
  logic ext_access;
  logic [3:0] cs_b_r;
  wire [3:0] area_hit;
  logic strap_rom_enable;
  logic [1:0] strap_rom_size;
  logic strap_single_chip;
  logic strap_area_zero_pin;
  logic strap_wide_package;

  // timing in short: decode is combinational from the cpu address,
  // selects, width and space register one edge later,
  // and the control register changes only through wishbone

  // true for the five spaces that reach the external pins
  function automatic logic is_external(input addr_decode_pkg::space_e kind);
    case (kind)
      addr_decode_pkg::SPACE_CS0,
      addr_decode_pkg::SPACE_CS1,
      addr_decode_pkg::SPACE_CS2,
      addr_decode_pkg::SPACE_CS3,
      addr_decode_pkg::SPACE_DRAM: is_external = 1'b1;
      default: is_external = 1'b0;
    endcase
  endfunction

  // space kind served by chip select number idx
  function automatic addr_decode_pkg::space_e area_space(input int idx);
    case (idx)
      0: area_space = addr_decode_pkg::SPACE_CS0;
      1: area_space = addr_decode_pkg::SPACE_CS1;
      2: area_space = addr_decode_pkg::SPACE_CS2;
      default: area_space = addr_decode_pkg::SPACE_CS3;
    endcase
  endfunction

  // reset release through two flip-flops
  // assertion stays asynchronous, release is clocked to keep recovery timing clean
  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      rst_sync1_r <= 1'b0;
      rst_sync2_r <= 1'b0;
    end
    else
    begin
      rst_sync1_r <= 1'b1;
      rst_sync2_r <= rst_sync1_r;
    end
  end
  assign rst_b = rst_sync2_r;

  // strap pins cross into the clock domain
  // straps are levels: a change shows two edges later, nothing decodes the first stage
  always_ff @(posedge core_clk_in or negedge rst_b)
  begin
    if (!rst_b)
    begin
      strap_sync1_r <= 6'h00;
      strap_sync2_r <= 6'h00;
    end
    else
    begin
      strap_sync1_r <= {wide_package_in, area_zero_mode_pin_in, single_chip_in, rom_size_in, rom_enable_in};
      strap_sync2_r <= strap_sync1_r;
    end
  end

  // synchronised strap fields by name
  assign strap_rom_enable = strap_sync2_r[0];
  assign strap_rom_size = strap_sync2_r[2:1];
  assign strap_single_chip = strap_sync2_r[3];
  assign strap_area_zero_pin = strap_sync2_r[4];
  assign strap_wide_package = strap_sync2_r[5];

  // wishbone request qualifier
  // a request still held in the ack cycle is not taken a second time
  assign wb_req = wb_cyc_in && wb_stb_in && (wb_state_r == addr_decode_pkg::WB_IDLE);

  // register write with byte lanes; reserved bits forced to zero
  always_comb
  begin
    bus_control_one_nxt = bus_control_one_r;
    if (wb_req && wb_we_in && wb_adr_in == addr_decode_pkg::BUS_CONTROL_ONE_OFFSET)
    begin
      if (wb_sel_in[0])
        bus_control_one_nxt[7:0] = wb_dat_in[7:0];
      if (wb_sel_in[1])
        bus_control_one_nxt[15:8] = wb_dat_in[15:8];
      bus_control_one_nxt = bus_control_one_nxt & addr_decode_pkg::BUS_CONTROL_ONE_WMASK;
    end
  end

  // bus control register, power-on reset only
  // no manual reset or standby input here, so contents survive all but power-on
  always_ff @(posedge core_clk_in or negedge rst_b)
  begin
    if (!rst_b)
      bus_control_one_r <= addr_decode_pkg::BUS_CONTROL_ONE_RESET;
    else
      bus_control_one_r <= bus_control_one_nxt;
  end

  // read mux; unmapped offsets read zero
  // reads have no side effects, so the mux follows the address freely
  always_comb
  begin
    case (wb_adr_in)
      addr_decode_pkg::BUS_CONTROL_ONE_OFFSET: rd_data = {16'h0000, bus_control_one_r};
      addr_decode_pkg::DECODE_STATUS_OFFSET: rd_data = {26'h0000000, width, space};
      addr_decode_pkg::MODE_STATUS_OFFSET: rd_data = {26'h0000000, strap_sync2_r};
      default: rd_data = 32'h00000000;
    endcase
  end

  // wishbone ack one cycle after request, dropped next cycle
  // ack comes from a register: one full cycle, never combinational from stb
  always_ff @(posedge core_clk_in or negedge rst_b)
  begin
    if (!rst_b)
      wb_state_r <= addr_decode_pkg::WB_IDLE;
    else
    begin
      case (wb_state_r)
        addr_decode_pkg::WB_IDLE:
          if (wb_req)
            wb_state_r <= addr_decode_pkg::WB_ACK;
        addr_decode_pkg::WB_ACK: wb_state_r <= addr_decode_pkg::WB_IDLE;
        default: wb_state_r <= addr_decode_pkg::WB_IDLE;
      endcase
    end
  end
  assign wb_ack_out = (wb_state_r == addr_decode_pkg::WB_ACK);

  // read data latched with the request
  // data stands from the ack until the next read
  always_ff @(posedge core_clk_in or negedge rst_b)
  begin
    if (!rst_b)
      wb_dat_out <= 32'h00000000;
    else if (wb_req && !wb_we_in)
      wb_dat_out <= rd_data;
  end

  // space decode
  space_classifier u_classifier (
    .addr_in(access_addr_in),
    .rom_enable_in(strap_rom_enable),
    .rom_size_in(strap_rom_size),
    .single_chip_in(strap_single_chip),
    .space_out(space)
  );

  // effective width, computed combinationally before outputs register
  width_selector u_width (
    .space_in(space),
    .control_in(bus_control_one_r),
    .addr_fourteen_in(access_addr_in[addr_decode_pkg::ADDR_BIT_FOURTEEN]),
    .rom_enable_in(strap_rom_enable),
    .area_zero_mode_pin_in(strap_area_zero_pin),
    .wide_package_in(strap_wide_package),
    .width_out(width)
  );

  // any access bound for the external pins
  assign ext_access = access_valid_in && is_external(space);

  // per-area hit, one decode per chip select
  for (genvar i = 0; i < 4; i++)
  begin : g_area_hit
    assign area_hit[i] = access_valid_in && (space == area_space(i));
  end

  // external address, held between external accesses
  always_ff @(posedge core_clk_in or negedge rst_b)
  begin
    if (!rst_b)
      ext_addr_out <= 22'h000000;
    else if (ext_access)
      ext_addr_out <= access_addr_in[21:0];
  end

  // registered active-low chip selects, one cycle after the access
  always_ff @(posedge core_clk_in or negedge rst_b)
  begin
    if (!rst_b)
      cs_b_r <= 4'hF;
    else
      cs_b_r <= ~area_hit;
  end
  assign chip_select_zero_b_out = cs_b_r[0];
  assign chip_select_one_b_out = cs_b_r[1];
  assign chip_select_two_b_out = cs_b_r[2];
  assign chip_select_three_b_out = cs_b_r[3];

  // dram select and multiplexed area-three qualifier
  always_ff @(posedge core_clk_in or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dram_select_out <= 1'b0;
      mux_area_access_out <= 1'b0;
    end
    else
    begin
      dram_select_out <= access_valid_in && space == addr_decode_pkg::SPACE_DRAM;
      mux_area_access_out <= area_hit[3] && bus_control_one_r[addr_decode_pkg::MUX_IO_BIT];
    end
  end

  // width and space registered with the selects, so strobes never see a stale width
  always_ff @(posedge core_clk_in or negedge rst_b)
  begin
    if (!rst_b)
    begin
      access_width_out <= 2'h0;
      access_space_out <= 4'h0;
    end
    else
    begin
      access_width_out <= width;
      access_space_out <= space;
    end
  end

  // control bits steering the rest of the chip
  // both act at once, with no register stage behind the control register
  assign timer_regs_access_enable_out = bus_control_one_r[addr_decode_pkg::TIMER_ACCESS_BIT];
  assign mux_io_enable_out = bus_control_one_r[addr_decode_pkg::MUX_IO_BIT];

endmodule

// file: address_space_decoder_checker.sv
// checker: concurrent assertions on the decoder ports
`timescale 1ns/1ps
module address_space_decoder_checker (
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic wb_ack_out,
  input wire logic single_chip_in,
  input wire logic access_valid_in,
  input wire logic [31:0] access_addr_in,
  input wire logic [21:0] ext_addr_out,
  input wire logic chip_select_zero_b_out,
  input wire logic chip_select_one_b_out,
  input wire logic chip_select_two_b_out,
  input wire logic chip_select_three_b_out,
  input wire logic dram_select_out,
  input wire logic [1:0] access_width_out,
  input wire logic timer_regs_access_enable_out,
  input wire logic mux_io_enable_out
);
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_b_in);
  // all four selects as one vector
  wire logic [3:0] cs_b = {chip_select_three_b_out, chip_select_two_b_out,
    chip_select_one_b_out, chip_select_zero_b_out};
  wire logic sel_ok = access_valid_in && !single_chip_in;
  // request taken while idle, then a single acknowledge
  sequence wb_req_s;
    wb_cyc_in && wb_stb_in && !wb_ack_out;
  endsequence
  sequence ack_pulse_s;
    wb_ack_out ##1 !wb_ack_out;
  endsequence
  // acknowledged write of the control register, upper lane enabled
  sequence ctl_wr_s;
    wb_ack_out && wb_we_in && wb_adr_in == 8'h00 && wb_sel_in[1];
  endsequence
  AST_ACK_PULSE: assert property (wb_req_s |=> ack_pulse_s)
    else $error("ack is not one pulse");
  AST_RSVD_ZERO: assert property (wb_ack_out && !wb_we_in |->
    {wb_dat_out[31:14], wb_dat_out[12:9]} == 22'h0) else $error("reserved bits read set");
  AST_TIMER_WR: assert property (ctl_wr_s |->
    timer_regs_access_enable_out == wb_dat_in[13]) else $error("timer enable not written");
  AST_MUX_WR: assert property (ctl_wr_s |-> mux_io_enable_out == wb_dat_in[8])
    else $error("mux enable not written");
  AST_TOP_BYTE: assert property (access_valid_in && access_addr_in[31:24] != 8'h00
    |=> cs_b == 4'hF) else $error("select outside external byte");
  AST_CS_AREA: assert property (sel_ok && access_addr_in[31:22] == 10'h001 |=>
    !chip_select_one_b_out && ext_addr_out == $past(access_addr_in[21:0])) else $error("area one decode");
  AST_MUX_WIDTH: assert property (sel_ok && mux_io_enable_out && access_addr_in[31:22] == 10'h003
    |=> access_width_out == {1'b0, $past(access_addr_in[14])}) else $error("mux width");
  AST_SINGLE: assert property (access_valid_in && single_chip_in |=>
    cs_b == 4'hF && !dram_select_out) else $error("select in single chip");
endmodule

bind address_space_decoder address_space_decoder_checker u_checker (
  .core_clk_in, .rst_b_in, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_sel_in,
  .wb_dat_in, .wb_dat_out, .wb_ack_out, .single_chip_in, .access_valid_in, .access_addr_in,
  .ext_addr_out, .chip_select_zero_b_out, .chip_select_one_b_out, .chip_select_two_b_out,
  .chip_select_three_b_out, .dram_select_out, .access_width_out, .timer_regs_access_enable_out,
  .mux_io_enable_out
);

// file: ext_bus_model.sv
// external device model: reports which device the selects address
`timescale 1ns/1ps
module ext_bus_model (
  input wire logic [3:0] cs_b_in,
  input wire logic dram_sel_in,
  output logic [2:0] hit_out
);
  // device 1..4 per select, 5 for dram, 0 idle; overlaps add up
  always_comb
  begin
    hit_out = dram_sel_in ? 3'h5 : 3'h0;
    for (int i = 0; i < 4; i++)
      if (!cs_b_in[i]) hit_out = hit_out + 3'(i + 1);
  end
endmodule

// file: address_space_decoder_bench.sv
// testbench: register access, strap modes and random decode checks
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_total++; $display("Error %0t: %h vs %h", $time, a, b); end end
module address_space_decoder_bench;
  logic core_clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic wb_cyc_in, wb_stb_in, wb_we_in, wb_ack_out, access_valid_in, dram, mux_acc;
  logic [7:0] wb_adr_in;
  logic [3:0] wb_sel_in, access_space_out, sx;
  wire [3:0] cs_b;
  logic [31:0] wb_dat_in, wb_dat_out, access_addr_in, rd, a;
  logic rom_enable_in, single_chip_in, area_zero_mode_pin_in, wide_package_in, tmr, mux_en;
  logic [1:0] rom_size_in, access_width_out;
  logic [21:0] ext_addr_out;
  logic [2:0] hit;
  logic [15:0] ctl;
  int err_total, total_checks, cycles;
  always #5 core_clk_in = ~core_clk_in;
  address_space_decoder u_dut (.core_clk_in, .rst_b_in, .wb_cyc_in, .wb_stb_in, .wb_we_in,
    .wb_adr_in, .wb_sel_in, .wb_dat_in, .wb_dat_out, .wb_ack_out, .rom_enable_in, .rom_size_in,
    .single_chip_in, .area_zero_mode_pin_in, .wide_package_in, .access_valid_in, .access_addr_in,
    .ext_addr_out, .chip_select_zero_b_out(cs_b[0]), .chip_select_one_b_out(cs_b[1]),
    .chip_select_two_b_out(cs_b[2]), .chip_select_three_b_out(cs_b[3]), .dram_select_out(dram),
    .mux_area_access_out(mux_acc), .access_width_out, .access_space_out,
    .timer_regs_access_enable_out(tmr), .mux_io_enable_out(mux_en));
  ext_bus_model u_ext (.cs_b_in(cs_b), .dram_sel_in(dram), .hit_out(hit));
  // classic single wishbone cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d, output logic [31:0] q);
    @(posedge core_clk_in);
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_we_in <= w;
    wb_adr_in <= ad;
    wb_dat_in <= d;
    do @(posedge core_clk_in); while (wb_ack_out !== 1'b1);
    q = wb_dat_out;
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
  endtask
  // expected space code of an address under the current straps
  function automatic logic [3:0] exp_space(logic [31:0] x, logic sc);
    logic [31:0] re;
    re = rom_size_in == 2'h2 ? addr_decode_pkg::ROM_64K_END :
      rom_size_in == 2'h1 ? addr_decode_pkg::ROM_128K_END : addr_decode_pkg::ROM_256K_END;
    if (x[31:24] == 8'h00)
    begin
      if (rom_enable_in && x <= re) return 4'h1;
      if (rom_enable_in && x < 32'h0020_0000) return 4'h0;
      return sc ? 4'h0 : 4'h2 + 4'(x[23:22]);
    end
    if (x[31:24] == 8'h01) return sc ? 4'h0 : 4'h6;
    if (x >= 32'hFFFF_8000 && x <= 32'hFFFF_87FF) return 4'h7;
    return x >= 32'hFFFF_F000 ? 4'h8 : 4'h0;
  endfunction
  function automatic logic [1:0] lw(logic l, logic s);
    return l ? 2'h2 : {1'b0, s};
  endfunction
  // expected effective width of a decoded access
  function automatic logic [1:0] exp_width(logic [3:0] s, logic a14);
    logic p;
    p = area_zero_mode_pin_in;
    case (s)
      4'h2: return rom_enable_in ? lw(ctl[4], ctl[0]) : wide_package_in ? {p, ~p} : {1'b0, p};
      4'h3, 4'h6: return lw(ctl[5], ctl[1]);
      4'h4: return lw(ctl[6], ctl[2]);
      4'h5: return ctl[8] ? {1'b0, a14} : lw(ctl[7], ctl[3]);
      4'h7: return 2'h1;
      default: return 2'h2;
    endcase
  endfunction
  // one cpu access, outputs checked after the sampling edge
  task automatic access(input logic [31:0] x);
    logic [3:0] s;
    s = exp_space(x, single_chip_in);
    @(posedge core_clk_in);
    access_valid_in <= 1'b1;
    access_addr_in <= x;
    @(posedge core_clk_in);
    access_valid_in <= 1'b0;
    #1;
    `CHK(cs_b, s inside {[2:5]} ? ~(4'h1 << (s - 4'h2)) : 4'hF)
    `CHK(hit, s inside {[2:6]} ? 3'(s - 4'h1) : 3'h0)
    `CHK(mux_acc, s == 4'h5 && ctl[8])
    if (s inside {[2:6]}) `CHK(ext_addr_out, x[21:0])
    `CHK({access_width_out, access_space_out}, {exp_width(s, x[14]), s})
  endtask
  // timeout guard
  always @(posedge core_clk_in)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      err_total++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    {wb_cyc_in, wb_stb_in, wb_we_in, access_valid_in, wb_adr_in} = 12'h0;
    wb_sel_in = 4'h3;
    wb_dat_in = 32'h0;
    access_addr_in = 32'h0;
    {rom_enable_in, rom_size_in, single_chip_in, area_zero_mode_pin_in, wide_package_in} = 6'h20;
    rd = $urandom(32'h99C0);
    repeat (3) @(posedge core_clk_in);
    rst_b_in <= 1'b1;
    repeat (6) @(posedge core_clk_in);
    wb(1'b0, 8'h00, 32'h0, rd);
    `CHK({rd, tmr, mux_en}, {32'h200F, 2'b10})
    wb(1'b0, 8'h08, 32'h0, rd);
    `CHK(rd, 32'h1)
    wb(1'b1, 8'h00, 32'hFFFF_FFFF, rd);
    wb(1'b0, 8'h00, 32'h0, rd);
    `CHK(rd, 32'h21FF)
    wb(1'b1, 8'h0C, 32'hFFFF_FFFF, rd);
    wb(1'b0, 8'h0C, 32'h0, rd);
    `CHK(rd, 32'h0)
    $display("test registers done");
    for (int k = 0; k < 10; k++)
    begin
      // power-on reset per mode: straps settle under it, control bits are set once after it
      @(posedge core_clk_in);
      rst_b_in <= 1'b0;
      rom_enable_in <= k[0];
      rom_size_in <= 2'($urandom % 3);
      single_chip_in <= k % 5 == 4;
      area_zero_mode_pin_in <= 1'($urandom);
      wide_package_in <= 1'($urandom);
      repeat (3) @(posedge core_clk_in);
      rst_b_in <= 1'b1;
      repeat (6) @(posedge core_clk_in);
      `CHK({tmr, mux_en}, 2'b10)
      wb(1'b0, 8'h08, 32'h0, rd);
      `CHK(rd, {26'h0, wide_package_in, area_zero_mode_pin_in, single_chip_in, rom_size_in, rom_enable_in})
      ctl = 16'($urandom) & addr_decode_pkg::BUS_CONTROL_ONE_WMASK;
      if (!wide_package_in) ctl[7:4] = 4'h0;
      wb(1'b1, 8'h00, {16'h0, ctl}, rd);
      `CHK({tmr, mux_en}, {ctl[13], ctl[8]})
      for (int j = 0; j < 40; j++)
      begin
        case ($urandom % 5)
          0: a = {8'h00, 24'($urandom)};
          1: a = {8'h01, 24'($urandom)};
          2: a = 32'hFFFF_8000 + ($urandom % 32'h800);
          3: a = 32'hFFFF_F000 + ($urandom % 32'h1000);
          default: a = $urandom % 32'h40000;
        endcase
        if (exp_space(a, 1'b0) != 4'h0) access(a);
      end
      sx = exp_space(access_addr_in, single_chip_in);
      wb(1'b0, 8'h04, 32'h0, rd);
      `CHK(rd, {26'h0, exp_width(sx, access_addr_in[14]), sx})
      $display("test mode %0d done", k);
    end
    give_verdict();
  end
endmodule
